// ===== rtl/clock_gen_regs.svh
// Function
// [RULE1] Skew steps of 1/32 period, full cycle
// [RULE2] Skew only among outputs sharing divide value
// [RULE3] Per-output drive type: LVCMOS, LVPECL, HCSL, LVDS
// [RULE4] Register enable per output; disabled holds 0
// [RULE5] LVCMOS pair: both pins toggle, shared settings
// [RULE6] Pair pins in phase or inverted
// [RULE7] Four stored configurations in OTP
// [RULE8] Serial overwrite only after reset completes
// [RULE9] Serially written configuration lost on reset
// [RULE10] Power-up reset lasts at most 10 ms
// [RULE11] After reset, load selected configuration
// [RULE12] Serial port answers only after full load
// [RULE13] Target answers at 0xD0 or 0xD4
// [RULE14] Byte-oriented block write and block read
// [RULE15] Two address bytes give start position
// [RULE16] Ascending byte order, MSB first
// [RULE17] Host may stop after any byte
// [RULE18] Buffer write bytes, commit all at STOP
// [RULE19] Host clock between 10 and 400 kHz
// [RULE20] Host idles 1.3 us between STOP, START
// [RULE21] Host clock high 0.6 us, low 1.3 us
// [RULE22] Default address 0xD4, 0xD0 when bit set
// [RULE23] Save/restore after STOP, no ack until done
// [RULE24] Strap low: ignore select pins, serial only
// [RULE25] No address ack during reset or loading
// [RULE26] Block read returns current committed contents
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

`define CLK_MHZ 50
`define POR_TIME_US 10000
`define REG_COUNT 128
`define NUM_CONFIG 4
`define NUM_OUT 2
`define TARGET_ADDR_DEFAULT 7'h6A
`define TARGET_ADDR_ALT 7'h68
`define ADDR_SEL_OFS 7'h00
`define ADDR_SEL_BIT 0
`define CMD_OFS 7'h72
`define CMD_SAVE_BIT 3
`define CMD_RESTORE_BIT 0
`define OUT_CTRL_OFS 7'h10
`define OUT_SKEW_OFS 7'h12
`define OUT_DIV_OFS 7'h14
`define CTRL_ENABLE_BIT 7
`define CTRL_INVERT_BIT 6
`define SKEW_MSB 4

`endif

// ===== rtl/clock_gen_pkg.sv
`include "clock_gen_regs.svh"

package clock_gen_pkg;

    typedef enum logic [1:0] {
        DRIVE_LVCMOS = 2'h0,
        DRIVE_LVPECL = 2'h1,
        DRIVE_HCSL = 2'h2,
        DRIVE_LVDS = 2'h3
    } drive_type;

    typedef struct packed {
        logic enable;
        drive_type drive;
        logic invert;
        logic [`SKEW_MSB:0] skew;
    } out_setting_type;

    typedef enum logic [2:0] {
        CTL_POR = 3'h0,
        CTL_LOAD = 3'h1,
        CTL_RUN = 3'h2,
        CTL_SAVE = 3'h3
    } ctl_state_type;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'h0,
        LINK_DEVADDR = 3'h1,
        LINK_ADDR_HI = 3'h2,
        LINK_ADDR_LO = 3'h3,
        LINK_WRITE = 3'h4,
        LINK_READ = 3'h5
    } link_state_type;

endpackage

// ===== rtl/clock_gen_config_port.sv
`include "clock_gen_regs.svh"

module clock_gen_config_port #(
    parameter int unsigned POR_CYCLES = `POR_TIME_US * `CLK_MHZ
)
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Internal power-up reset
    input wire logic scl, // Serial clock, link domain
    input wire logic sda_in, // Serial data level
    output logic sda_out, // Serial data drive value
    output logic sda_oe_n, // Low while pulling data low
    input wire logic interface_strap_pin, // Serial-only strap
    input wire logic config_choice_pin_low, // Config select bit 0
    input wire logic config_choice_pin_high, // Config select bit 1
    input wire logic [`NUM_OUT-1:0] divider_clk, // Divider outputs
    output logic [`NUM_OUT-1:0] clock_output_true_pin, // True pins
    output logic [`NUM_OUT-1:0] clock_output_complement_pin, // Compl.
    output clock_gen_pkg::out_setting_type [`NUM_OUT-1:0] out_setting,
    output logic config_loaded, // Configuration loaded
    output logic [1:0] active_config // Selected stored bank
);
    import clock_gen_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] regs [`REG_COUNT];
    logic [7:0] otp [`NUM_CONFIG][`REG_COUNT] = '{default: '{default: 8'h00}};
    logic [7:0] wbuf [`REG_COUNT];
    logic [`REG_COUNT-1:0] wmask;

    ctl_state_type state;
    logic [19:0] por_cnt;
    logic [6:0] idx;
    logic [1:0] bank;
    logic strap_latched;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic stop_meta;
    logic stop_sync;
    logic stop_last;
    logic commit;
    logic do_save;
    logic do_restore;

    link_state_type lstate;
    link_state_type after;
    logic start_tgl = 1'b0;
    logic stop_tgl = 1'b0;
    logic start_seen;
    logic link_rst_meta;
    logic link_rst;
    logic [1:0] status_meta;
    logic [1:0] status_sync;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] rbyte;
    logic [7:0] in_byte;
    logic [6:0] ptr;
    logic acking;
    logic drive_n;
    logic start_now;

    // ------------------------------------------------------------
    // Pin synchronisers and stop crossing
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end
        else
        begin
            pin_meta <= {interface_strap_pin, config_choice_pin_high,
                         config_choice_pin_low};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stop_meta <= 1'b0;
            stop_sync <= 1'b0;
            stop_last <= 1'b0;
        end
        else
        begin
            stop_meta <= stop_tgl;
            stop_sync <= stop_meta;
            stop_last <= stop_sync;
        end
    end

    // The write buffer is quiet after STOP because the bus is idle then.
    assign commit = (stop_sync != stop_last) && (state == CTL_RUN); // RULE18
    assign do_save = commit && wmask[`CMD_OFS]
        && wbuf[`CMD_OFS][`CMD_SAVE_BIT]; // RULE23
    assign do_restore = commit && wmask[`CMD_OFS]
        && wbuf[`CMD_OFS][`CMD_RESTORE_BIT]; // RULE23

    // ------------------------------------------------------------
    // Reset, self-configuration and store sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state <= CTL_POR;
            por_cnt <= 20'h00000;
            idx <= 7'h00;
            bank <= 2'h0;
            strap_latched <= 1'b0;
        end
        else
        begin
            case (state)
                CTL_POR:
                begin
                    if (por_cnt == 20'(POR_CYCLES - 1)) // RULE10
                    begin
                        state <= CTL_LOAD; // RULE11
                        idx <= 7'h00;
                        strap_latched <= pin_sync[2];
                        bank <= pin_sync[2] ? pin_sync[1:0] : 2'h0; // RULE24
                    end
                    else
                    begin
                        por_cnt <= por_cnt + 20'h00001;
                    end
                end
                CTL_LOAD, CTL_SAVE:
                begin
                    idx <= idx + 7'h01;
                    if (idx == 7'h7F)
                    begin
                        state <= CTL_RUN; // RULE12
                    end
                end
                CTL_RUN:
                begin
                    idx <= 7'h00;
                    if (do_save)
                    begin
                        state <= CTL_SAVE; // RULE23
                    end
                    else if (do_restore)
                    begin
                        state <= CTL_LOAD; // RULE23
                    end
                    else if (strap_latched && pin_sync[1:0] != bank)
                    begin
                        bank <= pin_sync[1:0];
                        state <= CTL_LOAD;
                    end
                end
                default:
                begin
                    state <= CTL_POR;
                end
            endcase
        end
    end

    // Working registers: cleared by reset, so serial writes do not survive.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
            begin
                regs[i] <= 8'h00; // RULE9
            end
        end
        else if (state == CTL_LOAD)
        begin
            regs[idx] <= otp[bank][idx]; // RULE11
        end
        else if (commit)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
            begin
                if (wmask[i])
                begin
                    regs[i] <= wbuf[i]; // RULE18
                end
            end
            regs[`CMD_OFS][`CMD_SAVE_BIT] <= 1'b0;
            regs[`CMD_OFS][`CMD_RESTORE_BIT] <= 1'b0;
        end
    end

    // Non-volatile banks keep their contents across reset.
    always_ff @(posedge clk)
    begin
        if (state == CTL_SAVE)
        begin
            otp[bank][idx] <= regs[idx]; // RULE7
        end
    end

    assign config_loaded = (state == CTL_RUN);
    assign active_config = bank;

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < `NUM_OUT; k++)
        begin : gen_out
            localparam logic [6:0] CTRL = 7'(`OUT_CTRL_OFS + k);
            localparam logic [6:0] SKEW = 7'(`OUT_SKEW_OFS + k);
            localparam logic [6:0] DIV = 7'(`OUT_DIV_OFS + k);
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    out_setting[k] <= '0;
                    clock_output_true_pin[k] <= 1'b0;
                    clock_output_complement_pin[k] <= 1'b0;
                end
                else
                begin
                    out_setting[k].enable <= regs[CTRL][`CTRL_ENABLE_BIT]; // RULE4
                    out_setting[k].drive <= drive_type'(regs[CTRL][1:0]); // RULE3
                    out_setting[k].invert <= regs[CTRL][`CTRL_INVERT_BIT]; // RULE6
                    // Skew counts 1/32 period units; 32 units wrap at 360.
                    out_setting[k].skew <= (regs[DIV] == regs[`OUT_DIV_OFS])
                        ? regs[SKEW][`SKEW_MSB:0] : 5'h00; // RULE1 RULE2
                    clock_output_true_pin[k] <= out_setting[k].enable
                        & divider_clk[k]; // RULE4
                    if (out_setting[k].drive == DRIVE_LVCMOS)
                    begin
                        clock_output_complement_pin[k] <= out_setting[k].enable
                            & (divider_clk[k] ^ out_setting[k].invert); // RULE5
                    end
                    else
                    begin
                        clock_output_complement_pin[k] <= out_setting[k].enable
                            & ~divider_clk[k];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // START and STOP detection on data edges
    // ------------------------------------------------------------
    always_ff @(negedge sda_in)
    begin
        if (scl)
        begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge sda_in)
    begin
        if (scl)
        begin
            stop_tgl <= ~stop_tgl; // RULE17
        end
    end

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    always_ff @(posedge scl)
    begin
        link_rst_meta <= sys_rst;
        link_rst <= link_rst_meta;
        status_meta <= {config_loaded & ~strap_latched,
                        regs[`ADDR_SEL_OFS][`ADDR_SEL_BIT]};
        status_sync <= status_meta;
    end

    // START toggles while the clock is high, long before the next rise.
    assign start_now = (start_seen != start_tgl);
    assign in_byte = {shreg[6:0], sda_in};

    always_ff @(posedge scl)
    begin
        if (link_rst)
        begin
            lstate <= LINK_IDLE;
            after <= LINK_IDLE;
            // Track the toggle so a START from before reset is not replayed.
            start_seen <= start_tgl;
            cnt <= 4'h0;
            shreg <= 8'h00;
            rbyte <= 8'h00;
            ptr <= 7'h00;
            acking <= 1'b0;
        end
        else if (start_now)
        begin
            start_seen <= start_tgl;
            lstate <= LINK_DEVADDR;
            cnt <= 4'h1;
            shreg <= {7'h00, sda_in}; // RULE16
            acking <= 1'b0;
        end
        else if (cnt == 4'h8)
        begin
            cnt <= 4'h0;
            if (lstate == LINK_READ)
            begin
                if (sda_in)
                begin
                    lstate <= LINK_IDLE; // RULE17
                    acking <= 1'b0;
                end
                else
                begin
                    ptr <= ptr + 7'h01; // RULE16
                    rbyte <= regs[ptr + 7'h01]; // RULE26
                end
            end
            else
            begin
                lstate <= acking ? after : LINK_IDLE;
                if (acking && after == LINK_READ)
                begin
                    rbyte <= regs[ptr]; // RULE26
                end
            end
        end
        else
        begin
            cnt <= cnt + 4'h1;
            shreg <= in_byte; // RULE16
            if (cnt == 4'h7)
            begin
                case (lstate)
                    LINK_DEVADDR:
                    begin
                        // Not ready: no ack, so the host polls.
                        acking <= status_sync[1] && in_byte[7:1] ==
                            (status_sync[0] ? `TARGET_ADDR_ALT
                                            : `TARGET_ADDR_DEFAULT); // RULE13 RULE22 RULE25 RULE8 RULE12
                        after <= in_byte[0] ? LINK_READ : LINK_ADDR_HI; // RULE14
                    end
                    LINK_ADDR_HI:
                    begin
                        acking <= 1'b1; // RULE15
                        after <= LINK_ADDR_LO;
                    end
                    LINK_ADDR_LO:
                    begin
                        acking <= 1'b1;
                        ptr <= in_byte[6:0]; // RULE15
                        after <= LINK_WRITE;
                    end
                    LINK_WRITE:
                    begin
                        acking <= 1'b1;
                        ptr <= ptr + 7'h01; // RULE16
                        after <= LINK_WRITE;
                    end
                    default:
                    begin
                        acking <= 1'b0;
                        after <= LINK_IDLE;
                    end
                endcase
            end
        end
    end

    // Write bytes wait here until STOP commits them together.
    always_ff @(posedge scl)
    begin
        if (link_rst || start_now)
        begin
            wmask <= '0;
        end
        else if (cnt == 4'h7 && lstate == LINK_WRITE)
        begin
            wbuf[ptr] <= in_byte; // RULE18
            wmask[ptr] <= 1'b1; // RULE18
        end
    end

    always_ff @(negedge scl)
    begin
        if (link_rst)
        begin
            drive_n <= 1'b1;
        end
        else if (lstate == LINK_READ)
        begin
            drive_n <= (cnt == 4'h8) | rbyte[3'h7 - cnt[2:0]]; // RULE16
        end
        else
        begin
            drive_n <= ~((cnt == 4'h8) & acking);
        end
    end

    assign sda_oe_n = drive_n;
    assign sda_out = 1'b0;

endmodule // clock_gen_config_port

// ===== sim/clock_gen_config_port_chk.sv
`include "clock_gen_regs.svh"

module clock_gen_config_port_chk #(
    parameter int unsigned POR_CYCLES = 20
)
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Reset
    input wire logic scl, // Serial clock
    input wire logic sda_oe_n, // Data pull
    input wire logic interface_strap_pin, // Strap
    input wire logic [1:0] divider_clk, // Divider levels
    input wire logic [1:0] clock_output_true_pin, // True pins
    input wire logic [1:0] clock_output_complement_pin, // Compl.
    input wire clock_gen_pkg::out_setting_type [1:0] out_setting, // Set
    input wire logic config_loaded, // Loaded
    input wire logic [1:0] active_config // Bank
);
    import clock_gen_pkg::*;

    // ------------
    // Helpers.
    // ------------
    logic [1:0] en, cmp;
    int unsigned cnt;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            en[k] = out_setting[k].enable;
            cmp[k] = out_setting[k].drive == DRIVE_LVCMOS ?
                divider_clk[k] ^ out_setting[k].invert : ~divider_clk[k];
        end
    end

    // Counts cycles from reset release until the load has finished.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cnt <= 0;
        else if (!config_loaded)
            cnt <= cnt + 1;
    end

    // ------------
    // Checks.
    // ------------
    chk_true_pin: assert property (
        clock_output_true_pin == $past(en & divider_clk))
        else $error("true pins wrong");
    chk_compl_pin: assert property (
        clock_output_complement_pin == $past(en & cmp))
        else $error("complement pins wrong");
    chk_commit_gap: assert property (
        !scl |-> $stable(out_setting))
        else $error("settings moved inside a frame");
    chk_no_early_ack: assert property (
        !config_loaded |-> sda_oe_n)
        else $error("ack while not loaded");
    chk_sda_timing: assert property (
        $changed(sda_oe_n) |-> !scl)
        else $error("data moved while clock high");
    chk_por_limit: assert property (
        !config_loaded |-> cnt <= POR_CYCLES + 200)
        else $error("load too slow");
    chk_load_span: assert property (
        $rose(config_loaded) |-> cnt >= POR_CYCLES + 120)
        else $error("load too short");
    chk_strap_bank: assert property (
        config_loaded && !interface_strap_pin |-> active_config == 2'h0)
        else $error("bank not zero");

    cover property ($rose(config_loaded));
    cover property (config_loaded && $fell(sda_oe_n));
    cover property (config_loaded && $changed(out_setting));
endmodule // clock_gen_config_port_chk

// ===== sim/host_model.sv
module host_model (
    output logic scl, // Serial clock
    output logic sda_low, // Pulls data low
    input wire logic sda // Resolved data wire
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------
    // Bus timing: low 2TQ, high TQ, 392 kHz.
    // ------------
    localparam int TQ = 850;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic bit_io(input logic tx, output logic rx);
        #TQ;
        sda_low = ~tx;
        #TQ;
        scl = 1'b1;
        #TQ;
        rx = sda;
        scl = 1'b0;
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic last,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, ack);
    endtask

    task automatic start();
        #TQ;
        sda_low = 1'b0;
        #TQ;
        scl = 1'b1;
        #TQ;
        sda_low = 1'b1;
        #TQ;
        scl = 1'b0;
    endtask

    task automatic stop();
        #TQ;
        sda_low = 1'b1;
        #TQ;
        scl = 1'b1;
        #TQ;
        sda_low = 1'b0;
    endtask

    // Short clock burst with data high, so no start or stop is seen.
    task automatic pulses();
        repeat (3)
        begin
            #15 scl = 1'b0;
            #15 scl = 1'b1;
        end
    endtask
endmodule // host_model

// ===== sim/test_clock_gen_config_port.sv
`include "clock_gen_regs.svh"

module test_clock_gen_config_port;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_gen_pkg::*;

    localparam int POR = 2000;

    logic clk, sys_rst, scl, sda_low, sda_oe_n, loaded, strap, a;
    logic sel_lo, sel_hi;
    logic [1:0] div_clk, true_pin, comp_pin, bank;
    out_setting_type [1:0] setting;
    logic [7:0] img [128];
    logic [7:0] q [$];
    int n_errors, compares;
    wire sda;

    assign sda = sda_oe_n & ~sda_low;

    clock_gen_config_port #(.POR_CYCLES(POR)) i_clock_gen_config_port (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
        .sda_out(), .sda_oe_n(sda_oe_n), .interface_strap_pin(strap),
        .config_choice_pin_low(sel_lo), .config_choice_pin_high(sel_hi),
        .divider_clk(div_clk), .clock_output_true_pin(true_pin),
        .clock_output_complement_pin(comp_pin), .out_setting(setting),
        .config_loaded(loaded), .active_config(bank));

    host_model i_host_model (.scl(scl), .sda_low(sda_low), .sda(sda));

    // ------------
    // Tasks.
    // ------------
    task automatic close_out();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic [7:0] rx;
        i_host_model.byte_io(b, 1'b1, rx, ack);
    endtask

    task automatic wr(input logic [7:0] dev, input logic [7:0] ofs,
        output logic ack);
        logic x;
        i_host_model.start();
        send(dev, ack);
        send(8'h00, x);
        send(ofs, x);
        foreach (q[i])
            send(q[i], x);
    endtask

    task automatic probe(input logic [7:0] dev, input logic exp);
        q = {};
        wr(dev, 8'h00, a);
        i_host_model.stop();
        check("address ack", exp, a);
    endtask

    task automatic rd(input logic [7:0] dev, input logic [7:0] ofs,
        input int n);
        logic x;
        logic [7:0] rx;
        q = {};
        wr(dev, ofs, x);
        i_host_model.start();
        send(dev | 8'h01, x);
        for (int i = 0; i < n; i++)
        begin
            i_host_model.byte_io(8'hFF, i == n - 1, rx, x);
            check("read byte", img[(ofs + i) % 128], rx);
        end
        i_host_model.stop();
    endtask

    function automatic out_setting_type exp_set(input int k);
        out_setting_type s;
        s.enable = img[`OUT_CTRL_OFS + k][`CTRL_ENABLE_BIT];
        s.invert = img[`OUT_CTRL_OFS + k][`CTRL_INVERT_BIT];
        s.drive = drive_type'(img[`OUT_CTRL_OFS + k][1:0]);
        s.skew = img[`OUT_DIV_OFS + k] == img[`OUT_DIV_OFS] ?
            img[`OUT_SKEW_OFS + k][4:0] : 5'h00;
        return s;
    endfunction

    task automatic do_reset();
        @(posedge clk);
        #1 sys_rst = 1'b1;
        foreach (img[i])
            img[i] = 8'h00;
        fork
            i_host_model.pulses();
            repeat (5) @(posedge clk);
        join
        #1 sys_rst = 1'b0;
    endtask

    task automatic wait_loaded();
        for (int i = 0; i < POR + 400 && loaded !== 1'b1; i++)
            @(posedge clk);
        check("loaded", 1, loaded);
        i_host_model.pulses();
    endtask

    // ------------
    // Stimulus.
    // ------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
        #1 div_clk = 2'($urandom);

    initial
    begin
        void'($urandom(32'hF4DD));
        sys_rst = 1'b1;
        strap = 1'b0;
        sel_lo = 1'($urandom);
        sel_hi = 1'($urandom);
        n_errors = 0;
        compares = 0;
        do_reset();
        probe(8'hD4, 1'b1);
        wait_loaded();
        $display("test early access done");
        for (int it = 0; it < 4; it++)
        begin
            q = {8'($urandom), 8'($urandom), 8'($urandom),
                8'($urandom), 8'($urandom), 8'($urandom)};
            q[0][1:0] = 2'(it);
            q[1][1:0] = 2'(it + 1);
            if (it % 2 == 1)
                q[5] = q[4];
            if (it == 3)
                q = q[0:2];
            wr(8'hD4, `OUT_CTRL_OFS, a);
            check("write ack", 0, a);
            @(negedge clk);
            for (int k = 0; k < 2; k++)
                check("held", exp_set(k), setting[k]);
            i_host_model.stop();
            repeat (10) @(negedge clk);
            foreach (q[i])
                img[`OUT_CTRL_OFS + i] = q[i];
            for (int k = 0; k < 2; k++)
                check("new", exp_set(k), setting[k]);
        end
        $display("test settings done");
        rd(8'hD4, `OUT_DIV_OFS, 3);
        $display("test read done");
        probe(8'hD0, 1'b1);
        q = {8'h01};
        wr(8'hD4, `ADDR_SEL_OFS, a);
        i_host_model.stop();
        img[`ADDR_SEL_OFS] = 8'h01;
        rd(8'hD0, `ADDR_SEL_OFS, 1);
        probe(8'hD4, 1'b1);
        $display("test address done");
        do_reset();
        wait_loaded();
        for (int k = 0; k < 2; k++)
            check("reset setting", 0, setting[k]);
        rd(8'hD4, `OUT_CTRL_OFS, 2);
        $display("test second reset done");
        @(posedge clk);
        #1 strap = 1'b1;
        do_reset();
        wait_loaded();
        check("strap bank", {sel_hi, sel_lo}, bank);
        probe(8'hD4, 1'b1);
        $display("test strap done");
        close_out();
    end

    // The tests need about 1.7 ms of bus time.
    initial
    begin
        #2000000;
        n_errors++;
        close_out();
    end
endmodule // test_clock_gen_config_port

bind clock_gen_config_port clock_gen_config_port_chk #(
    .POR_CYCLES(POR_CYCLES)) i_clock_gen_config_port_chk (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_oe_n(sda_oe_n),
    .interface_strap_pin(interface_strap_pin), .divider_clk(divider_clk),
    .clock_output_true_pin(clock_output_true_pin),
    .clock_output_complement_pin(clock_output_complement_pin),
    .out_setting(out_setting), .config_loaded(config_loaded),
    .active_config(active_config));
